/* rtl/cfg_switch_pkg.sv */
// Purpose: shared constants and carriers for the node configuration loader
// Assumes: switches are active high (on = 1)
// Notes: rate codes carry the decoded divisor for a 16x oversampled uart
package cfg_switch_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned RATE_W = 2;
    localparam int unsigned SW_W = 8;
    // switch field positions
    localparam int unsigned ADDR_LSB = 0;
    localparam int unsigned RATE_LSB = 6;
    // decoded rate codes
    localparam logic [1:0] RATE_NVM = 2'h0;
    localparam logic [1:0] RATE_9K6 = 2'h1;
    localparam logic [1:0] RATE_38K4 = 2'h2;
    localparam logic [1:0] RATE_115K2 = 2'h3;
    // bit rates in bits per second, clock in hertz
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned BPS_9K6 = 9600;
    localparam int unsigned BPS_38K4 = 38400;
    localparam int unsigned BPS_115K2 = 115200;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned DIV_W = 16;
    localparam logic [15:0] DIV_9K6 =
        16'(CLK_HZ / (BPS_9K6 * OVERSAMPLE));
    localparam logic [15:0] DIV_38K4 =
        16'(CLK_HZ / (BPS_38K4 * OVERSAMPLE));
    localparam logic [15:0] DIV_115K2 =
        16'(CLK_HZ / (BPS_115K2 * OVERSAMPLE));
    // reset values
    localparam logic [5:0] ADDR_RST = 6'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_SETTLE = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_HOLD = 2'b10
    } load_state_t;

    typedef struct packed {
        logic [5:0] node_addr;
        logic [1:0] rate_code;
        logic [15:0] rate_div;
        logic addr_from_nvm;
        logic rate_from_nvm;
        logic rs485_mode;
    } node_cfg_t;

    typedef struct packed {
        logic chan_a;
        logic chan_b;
        logic index;
    } enc_t;
endpackage

/* rtl/pin_sync2.sv */
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module pin_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [WIDTH-1:0] async_i, // raw pin levels
    output logic [WIDTH-1:0] sync_o // synchronised levels
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
        if (rst_i) begin
            next_meta = '0;
            next_sync = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        meta <= next_meta;
        sync_o <= next_sync;
    end
endmodule // pin_sync2

/* rtl/node_cfg_loader.sv */
// Purpose: captures serial node address and bit rate from eight switches,
//          and mirrors motor encoder channels onto buffered pairs
// Assumes: 25 MHz sys_clk_i, synchronous active-high rst_i
// Notes: settings are latched once after reset and held until next reset
//
// Overview of operation
// - switches one to six form node address
// - switches seven and eight form rate code
// - zero address selects stored non-volatile address
// - zero rate code selects stored bit rate
// - codes one two three give 9.6/38.4/115.2
// - switch settings apply in RS-485 mode only
// - encoder A and B mirrored as differential
// - encoder index mirrored as differential pair
// - grounded select input means RS-485, else RS-232
`timescale 1ns/100ps
module node_cfg_loader
    import cfg_switch_pkg::*;
(
    input wire logic sys_clk_i, // 25 MHz system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [7:0] cfg_switch_i, // switch 1 at bit 0, on = 1
    input wire logic iface_select_i, // low = RS-485, high = RS-232
    input wire logic [5:0] nvm_node_addr_i, // address from nvm
    input wire logic [1:0] nvm_rate_code_i, // rate code from nvm
    input wire logic mot_enc_a_i, // motor encoder channel A
    input wire logic mot_enc_b_i, // motor encoder channel B
    input wire logic mot_enc_index_i, // motor encoder index
    output logic rs485_mode_o, // 1 = serial port runs as RS-485
    output logic cfg_valid_o, // switch settings captured and applied in RS-485 mode
    output logic [5:0] node_addr_o, // effective RS-485 node address
    output logic [1:0] rate_code_o, // effective RS-485 rate code
    output logic [15:0] rate_div_o, // 16x oversample divisor
    output logic addr_from_nvm_o, // address came from nvm
    output logic rate_from_nvm_o, // rate came from nvm
    output logic encoder_chan_a_buffered_pos_o, // channel A true
    output logic encoder_chan_a_buffered_neg_o, // channel A inverted
    output logic encoder_chan_b_buffered_pos_o, // channel B true
    output logic encoder_chan_b_buffered_neg_o, // channel B inverted
    output logic encoder_index_buffered_pos_o, // index true
    output logic encoder_index_buffered_neg_o // index inverted
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [7:0] sw_sync;
    logic sel_sync;
    enc_t enc_sync;

    pin_sync2 #(.WIDTH(12)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({cfg_switch_i, iface_select_i,
                  mot_enc_a_i, mot_enc_b_i, mot_enc_index_i}),
        .sync_o({sw_sync, sel_sync, enc_sync})
    );

    // ****************************************
    // decode of switch fields
    // ****************************************
    logic [5:0] sw_addr;
    logic [1:0] sw_rate;

    assign sw_addr = sw_sync[ADDR_LSB +: ADDR_W];
    assign sw_rate = sw_sync[RATE_LSB +: RATE_W];

    function automatic logic [15:0] rate_to_div(input logic [1:0] code);
        logic [15:0] div;
        div = DIV_RST;
        case (code)
            RATE_9K6: div = DIV_9K6;
            RATE_38K4: div = DIV_38K4;
            RATE_115K2: div = DIV_115K2;
            default: div = DIV_RST;
        endcase
        return div;
    endfunction

    // ****************************************
    // capture state machine
    // ****************************************
    // the sync pipe needs two edges after reset before the switch levels
    // are real, so ST_SETTLE spends one cycle before ST_SAMPLE captures
    load_state_t state;
    load_state_t next_state;
    node_cfg_t cfg;
    node_cfg_t next_cfg;
    logic valid;
    logic next_valid;
    logic [5:0] eff_addr;
    logic [1:0] eff_rate;
    logic use_nvm_addr;
    logic use_nvm_rate;

    always_comb begin
        use_nvm_addr = (sw_addr == ADDR_RST);
        use_nvm_rate = (sw_rate == RATE_NVM);
        eff_addr = use_nvm_addr ? nvm_node_addr_i : sw_addr;
        eff_rate = use_nvm_rate ? nvm_rate_code_i : sw_rate;
        next_state = state;
        next_cfg = cfg;
        next_valid = valid;
        // port mode follows the select pin continuously
        next_cfg.rs485_mode = ~sel_sync;
        case (state)
            ST_RESET: begin
                next_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                next_state = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                next_state = ST_HOLD;
                next_valid = 1'b1;
                next_cfg.node_addr = eff_addr;
                next_cfg.rate_code = eff_rate;
                next_cfg.rate_div = rate_to_div(eff_rate);
                next_cfg.addr_from_nvm = use_nvm_addr;
                next_cfg.rate_from_nvm = use_nvm_rate;
            end
            ST_HOLD: begin
                next_state = ST_HOLD;
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
        if (rst_i) begin
            next_state = ST_RESET;
            next_valid = 1'b0;
            next_cfg = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        state <= next_state;
        cfg <= next_cfg;
        valid <= next_valid;
    end

    // ****************************************
    // output registers
    // ****************************************
    // in RS-232 mode the switch-derived fields read zero so the serial core
    // keeps its own RS-232 settings untouched by any switch position
    logic next_mode;
    logic next_gate;
    logic [5:0] next_addr_out;
    logic [1:0] next_code_out;
    logic [15:0] next_div_out;
    logic next_addr_flag;
    logic next_rate_flag;

    always_comb begin
        // mode is held off until the select level has crossed the
        // synchroniser, so a release of reset never flashes RS-485 mode
        next_mode = valid & cfg.rs485_mode;
        next_gate = valid & cfg.rs485_mode;
        next_addr_out = ADDR_RST;
        next_code_out = RATE_NVM;
        next_div_out = DIV_RST;
        next_addr_flag = 1'b0;
        next_rate_flag = 1'b0;
        if (next_gate) begin
            next_addr_out = cfg.node_addr;
            next_code_out = cfg.rate_code;
            next_div_out = cfg.rate_div;
            next_addr_flag = cfg.addr_from_nvm;
            next_rate_flag = cfg.rate_from_nvm;
        end
        if (rst_i) begin
            next_mode = 1'b0;
            next_gate = 1'b0;
            next_addr_out = ADDR_RST;
            next_code_out = RATE_NVM;
            next_div_out = DIV_RST;
            next_addr_flag = 1'b0;
            next_rate_flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        rs485_mode_o <= next_mode;
        cfg_valid_o <= next_gate;
        node_addr_o <= next_addr_out;
        rate_code_o <= next_code_out;
        rate_div_o <= next_div_out;
        addr_from_nvm_o <= next_addr_flag;
        rate_from_nvm_o <= next_rate_flag;
    end

    // ****************************************
    // encoder mirrors
    // ****************************************
    // true and inverted copies come from one synchronised level, so the
    // pair stays complementary outside reset, where both read low; the cost is three cycles of pin delay
    logic [2:0] enc_bits;
    logic [2:0] next_pos;
    logic [2:0] next_neg;
    logic [2:0] enc_pos;
    logic [2:0] enc_neg;

    assign enc_bits = enc_sync;

    for (genvar ch = 0; ch < 3; ch++) begin : g_enc
        always_comb begin
            next_pos[ch] = enc_bits[ch];
            next_neg[ch] = ~enc_bits[ch];
            if (rst_i) begin
                next_pos[ch] = 1'b0;
                next_neg[ch] = 1'b0;
            end
        end

        always_ff @(posedge sys_clk_i) begin
            enc_pos[ch] <= next_pos[ch];
            enc_neg[ch] <= next_neg[ch];
        end
    end

    // bit 2 carries channel A, bit 1 channel B, bit 0 the index
    assign encoder_chan_a_buffered_pos_o = enc_pos[2];
    assign encoder_chan_a_buffered_neg_o = enc_neg[2];
    assign encoder_chan_b_buffered_pos_o = enc_pos[1];
    assign encoder_chan_b_buffered_neg_o = enc_neg[1];
    assign encoder_index_buffered_pos_o = enc_pos[0];
    assign encoder_index_buffered_neg_o = enc_neg[0];
endmodule // node_cfg_loader

/* dv/nvm_store_model.sv */
// Purpose: stored settings that the drive keeps in non-volatile memory
// Assumes: contents change only while the drive is held in reset
// Notes: fixed seed so every run sees the same contents
`timescale 1ns/100ps
module nvm_store_model (
    input wire logic sys_clk_i, // clock
    input wire logic reload_i, // pick new contents
    output logic [5:0] node_addr_o, // stored address
    output logic [1:0] rate_code_o // stored rate code
);
    int seed = 32'h7a31;
    always @(posedge sys_clk_i) begin
        if (reload_i) begin
            {node_addr_o, rate_code_o} <= 8'($random(seed));
        end
    end
endmodule // nvm_store_model

/* dv/node_cfg_checker.sv */
// Purpose: port checks for the node configuration loader
// Assumes: stored settings change only during reset
// Notes: margins of five or six cycles cover the pin synchronisers
`timescale 1ns/100ps
module node_cfg_checker (
    input wire logic sys_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic iface_select_i, // mode pin
    input wire logic [5:0] nvm_node_addr_i, // stored address
    input wire logic [1:0] nvm_rate_code_i, // stored code
    input wire logic mot_enc_a_i, // encoder a
    input wire logic mot_enc_b_i, // encoder b
    input wire logic mot_enc_index_i, // encoder index
    input wire logic rs485_mode_o, // mode
    input wire logic cfg_valid_o, // valid
    input wire logic [5:0] node_addr_o, // address
    input wire logic [1:0] rate_code_o, // rate code
    input wire logic [15:0] rate_div_o, // divisor
    input wire logic addr_from_nvm_o, // address flag
    input wire logic rate_from_nvm_o, // rate flag
    input wire logic encoder_chan_a_buffered_pos_o, // a true
    input wire logic encoder_chan_a_buffered_neg_o, // a inverted
    input wire logic encoder_chan_b_buffered_pos_o, // b true
    input wire logic encoder_chan_b_buffered_neg_o, // b inverted
    input wire logic encoder_index_buffered_pos_o, // index true
    input wire logic encoder_index_buffered_neg_o // index inverted
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_addr_nvm_use: assert property (
        cfg_valid_o && addr_from_nvm_o |-> node_addr_o == nvm_node_addr_i)
        else $error("stored address not used");
    chk_addr_sw_nonzero: assert property (
        cfg_valid_o && !addr_from_nvm_o |-> node_addr_o != 6'h00)
        else $error("zero switch address used");
    chk_rate_nvm_use: assert property (
        cfg_valid_o && rate_from_nvm_o |-> rate_code_o == nvm_rate_code_i)
        else $error("stored rate not used");
    chk_rate_div_table: assert property (
        cfg_valid_o |-> rate_div_o == (rate_code_o == 2'h1 ? 16'h00a2 :
        rate_code_o == 2'h2 ? 16'h0028 : rate_code_o == 2'h3 ? 16'h000d
        : 16'h0000)) else $error("rate divisor wrong");
    chk_rs232_quiet: assert property (
        $past(!rs485_mode_o) && !rs485_mode_o |-> !cfg_valid_o &&
        node_addr_o == 6'h00) else $error("switch settings in rs232 mode");
    chk_mode_follow: assert property (
        iface_select_i [*6] |-> !rs485_mode_o)
        else $error("rs485 mode with select high");
    chk_enc_ab_mirror: assert property (
        ($stable(mot_enc_a_i) && $stable(mot_enc_b_i)) [*5] |->
        encoder_chan_a_buffered_pos_o == mot_enc_a_i &&
        encoder_chan_a_buffered_neg_o == !mot_enc_a_i &&
        encoder_chan_b_buffered_pos_o == mot_enc_b_i &&
        encoder_chan_b_buffered_neg_o == !mot_enc_b_i)
        else $error("encoder a or b not mirrored");
    chk_enc_index_mirror: assert property (
        $stable(mot_enc_index_i) [*5] |->
        encoder_index_buffered_pos_o == mot_enc_index_i &&
        encoder_index_buffered_neg_o == !mot_enc_index_i)
        else $error("encoder index not mirrored");
    chk_cfg_hold: assert property (
        cfg_valid_o && $past(cfg_valid_o) |-> $stable(node_addr_o) &&
        $stable(rate_div_o)) else $error("captured settings moved");
endmodule // node_cfg_checker
bind node_cfg_loader node_cfg_checker u_chk (.sys_clk_i, .rst_i,
    .iface_select_i, .nvm_node_addr_i, .nvm_rate_code_i, .mot_enc_a_i,
    .mot_enc_b_i, .mot_enc_index_i, .rs485_mode_o, .cfg_valid_o,
    .node_addr_o, .rate_code_o, .rate_div_o, .addr_from_nvm_o,
    .rate_from_nvm_o, .encoder_chan_a_buffered_pos_o,
    .encoder_chan_a_buffered_neg_o, .encoder_chan_b_buffered_pos_o,
    .encoder_chan_b_buffered_neg_o, .encoder_index_buffered_pos_o,
    .encoder_index_buffered_neg_o);

/* dv/node_cfg_loader_tb.sv */
// Purpose: self-checking bench for the node configuration loader
// Assumes: inputs move 2 ns after the rising edge
// Notes: each pass resets, captures, then moves the switches
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module node_cfg_loader_tb;
    logic sys_clk_i = 0, rst_i = 1, iface_select_i = 0, reload = 0;
    logic [7:0] cfg_switch_i = 8'h00;
    logic mot_enc_a_i = 0, mot_enc_b_i = 0, mot_enc_index_i = 0;
    logic [5:0] nvm_node_addr_i, node_addr_o;
    logic [1:0] nvm_rate_code_i, rate_code_o;
    logic [15:0] rate_div_o;
    logic rs485_mode_o, cfg_valid_o, addr_from_nvm_o, rate_from_nvm_o;
    logic ap, an, bp, bn, ip, in;
    int seed = 32'h4493, fail_count = 0, n_checks = 0, cyc = 0;
    logic [7:0] corner [4] = '{8'h00, 8'hff, 8'h41, 8'hbe};
    nvm_store_model nvm (.sys_clk_i, .reload_i(reload),
        .node_addr_o(nvm_node_addr_i), .rate_code_o(nvm_rate_code_i));
    node_cfg_loader dut (.sys_clk_i, .rst_i, .cfg_switch_i, .iface_select_i,
        .nvm_node_addr_i, .nvm_rate_code_i, .mot_enc_a_i, .mot_enc_b_i,
        .mot_enc_index_i, .rs485_mode_o, .cfg_valid_o, .node_addr_o,
        .rate_code_o, .rate_div_o, .addr_from_nvm_o, .rate_from_nvm_o,
        .encoder_chan_a_buffered_pos_o(ap), .encoder_chan_a_buffered_neg_o(an),
        .encoder_chan_b_buffered_pos_o(bp), .encoder_chan_b_buffered_neg_o(bn),
        .encoder_index_buffered_pos_o(ip), .encoder_index_buffered_neg_o(in));
    initial forever #20 sys_clk_i = ~sys_clk_i;
    // hang guard: a full run needs about 320 cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fail_count++;
            complete_run();
        end
    end
    function automatic logic [15:0] exp_div(input logic [1:0] c);
        return c == 2'h1 ? 16'h00a2 : c == 2'h2 ? 16'h0028 :
            c == 2'h3 ? 16'h000d : 16'h0000;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    // sw is the word present at capture, not the live switches
    task automatic check(input logic [7:0] sw);
        logic on;
        logic [1:0] c;
        on = !iface_select_i;
        c = (sw[7:6] == 2'h0) ? nvm_rate_code_i : sw[7:6];
        `CHK("mode", on, rs485_mode_o)
        `CHK("valid", on, cfg_valid_o)
        `CHK("addr", on ? (sw[5:0] == 6'h00 ? nvm_node_addr_i : sw[5:0])
            : 6'h00, node_addr_o)
        `CHK("code", on ? c : 2'h0, rate_code_o)
        `CHK("div", on ? exp_div(c) : 16'h0000, rate_div_o)
        `CHK("flags", on ? {sw[5:0] == 6'h00, sw[7:6] == 2'h0} : 2'h0,
            {addr_from_nvm_o, rate_from_nvm_o})
        `CHK("enc", {mot_enc_a_i, mot_enc_b_i, mot_enc_index_i,
            ~mot_enc_a_i, ~mot_enc_b_i, ~mot_enc_index_i},
            {ap, bp, ip, an, bn, in})
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        logic [7:0] sw;
        for (int i = 0; i < 12; i++) begin
            sw = (i < 4) ? corner[i] : 8'($random(seed));
            rst_i = 1;
            reload = 1;
            cfg_switch_i = sw;
            iface_select_i = (i == 5);
            step(1);
            reload = 0;
            step(11);
            rst_i = 0;
            step(8);
            check(sw);
            cfg_switch_i = ~sw;
            {mot_enc_a_i, mot_enc_b_i, mot_enc_index_i} = 3'($random(seed));
            step(6);
            check(sw);
        end
        complete_run();
    end
endmodule // node_cfg_loader_tb
